/* File: hdl/swcfg_pkg.sv */
// Package of constants for the switch address and configuration block.
// Assumes a 20 MHz clock; the block and the testbench refer to names here with pkg:: scope.
package swcfg_pkg;

  // Clock rate and derived timing.
  localparam int unsigned CLK_HZ = 20000000;
  // Settling time of the switches; one millisecond outlasts the contact bounce.
  localparam int unsigned DEBOUNCE_US = 1000;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int unsigned FAST_MS = 100;
  localparam int unsigned FAST_CYC = (CLK_HZ / 1000) * FAST_MS;
  localparam int unsigned SLOW_MS = 1000;
  localparam int unsigned SLOW_CYC = (CLK_HZ / 1000) * SLOW_MS;

  // Slot count and widths.
  localparam int unsigned NUM_SLOTS = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned OPT_W = 8;

  // Address arithmetic.
  localparam logic [7:0] DIGIT_WEIGHT = 8'h10;
  localparam logic [7:0] ADDR_MAX = 8'h7f;
  localparam logic [7:0] OFFSET_ADD = 8'h80;
  localparam logic [7:0] SLOT_STEP = 8'h01;
  localparam logic [7:0] SW_DEFAULT_CODE = 8'h00;

  // Option switch bank field positions.
  localparam int unsigned OPT_SETUP_BIT = 0;
  localparam int unsigned OPT_CKSUM_BIT = 1;
  localparam int unsigned OPT_BAUD_LSB = 2;
  localparam int unsigned OPT_MODE_BIT = 5;

  // Baud codes and default settings.
  localparam logic [2:0] BAUD_115200 = 3'h7;
  localparam logic DEF_SETUP = 1'b1;
  localparam logic DEF_CKSUM = 1'b0;
  localparam logic DEF_MODE = 1'b0;

  // Per-slot setup states reported by the slot manager.
  localparam logic [1:0] ST_EMPTY = 2'h0;
  localparam logic [1:0] ST_BUSY = 2'h1;
  localparam logic [1:0] ST_PASS = 2'h2;
  localparam logic [1:0] ST_FAIL = 2'h3;

  // Register map of the plain register port.
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_CPU_ADDR = 4'h1;
  localparam logic [3:0] REG_SLOT0_ADDR = 4'h2;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h3;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] REG_SLOT_STATE = 4'h6;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_CHANGE = 0;
  localparam int unsigned IRQ_FAIL = 1;
  localparam int unsigned IRQ_DONE = 2;

  // States of the parameter apply sequencer.
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_PUSH = 3'b010,
    SEQ_WAIT = 3'b100
  } seq_state_t;

endpackage

/* File: hdl/switch_debounce.sv */
// Synchroniser and debouncer for a bank of switch inputs.
// Assumes slow mechanical inputs and one clock; output changes only after a stable period.
`timescale 1ns/1ns
module switch_debounce #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned STABLE_CYC = 200000
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Raw and clean switch levels.
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] clean_out
);

  logic [WIDTH-1:0] sync1_ff; // First synchroniser stage, read only by the second.
  logic [WIDTH-1:0] sync2_ff; // Second synchroniser stage.
  logic [WIDTH-1:0] last_ff; // Value seen on the previous cycle.
  logic [23:0] cnt_ff; // Stable-time counter.

  // Two-stage synchroniser.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // The value is accepted only after it holds still for the full period.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_ff <= '0;
      cnt_ff <= '0;
      clean_out <= '0;
    end else begin
      last_ff <= sync2_ff;
      if (sync2_ff != last_ff) begin
        cnt_ff <= '0;
      end else if (cnt_ff < 24'(STABLE_CYC - 1)) begin
        cnt_ff <= cnt_ff + 24'h000001;
      end else begin
        clean_out <= sync2_ff;
      end
    end
  end

endmodule // switch_debounce

/* File: hdl/switch_address_config.sv */
// Switch address and configuration logic of a multi-slot remote I/O carrier.
// Assumes switches are slow levels and slot setup results come from a slot manager.
// Overview of operation
// - Address equals high digit times sixteen plus low.
// - Slot addresses above 127 clear addr_valid.
// - Switch code 00 forces default options.
// - Option bank: setup, checksum, baud, offset mode.
// - Slots get device baud and checksum.
// - Offset mode: device plus 128, slot0 switch.
// - Normal mode: device switch, slot0 plus one.
// - Each next slot address is one higher.
// - Slot lamp toggles 100 ms during setup.
// - Slot lamp flashes slowly on setup failure.
// - Ready lamp fast, steady, or slow flashing.
// - Setup lamp follows automatic setup enable.
// - Switch changes re-apply parameters without software.
`timescale 1ns/1ns
module switch_address_config (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Switch inputs.
  input wire logic [3:0] rotary_hi,
  input wire logic [3:0] rotary_lo,
  input wire logic [7:0] option_switch_bank,
  // Slot setup results from the slot manager, two bits per slot.
  input wire logic [15:0] slot_state,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Decoded parameters pushed to the serial port and slots.
  output logic [7:0] dev_addr,
  output logic [63:0] slot_addr,
  output logic addr_valid,
  output logic auto_setup,
  output logic cksum_en,
  output logic [2:0] baud_code,
  output logic [2:0] slot_baud,
  output logic slot_cksum,
  output logic param_apply,
  // Indicators and interrupt.
  output logic [7:0] slot_led,
  output logic ready_led,
  output logic setup_led,
  output logic irq
);

  logic [15:0] clean_sw; // Debounced rotary digits and options.
  logic [7:0] sw_addr; // Address read from the rotary digits.
  logic [7:0] opt; // Debounced option bank.
  logic def_sel; // Default options forced.
  logic nxt_setup, nxt_cksum, nxt_mode; // Effective options.
  logic [2:0] nxt_baud; // Effective baud code.
  logic [7:0] nxt_dev; // Next device address.
  logic [7:0] nxt_base; // Next slot 0 address.
  logic nxt_valid; // All slot addresses within range.
  logic [15:0] prev_sw_ff; // Last applied switch image.
  logic changed; // Switch image differs from applied one.
  swcfg_pkg::seq_state_t seq_ff; // Apply sequencer state.
  logic [22:0] fast_cnt_ff; // Fast blink divider.
  logic [24:0] slow_cnt_ff; // Slow blink divider, wide enough for one second.
  logic [63:0] nxt_slot; // Next slot addresses, one byte per slot.
  logic fast_ff, slow_ff; // Blink phases.
  logic [7:0] busy_v, fail_v; // Per-slot status.
  logic [2:0] irq_stat_ff, irq_en_ff; // Interrupt status and enable.
  logic [2:0] irq_set; // Interrupt events this cycle.
  logic [7:0] fail_prev_ff; // Fail vector last cycle.
  logic busy_prev_ff; // Any busy last cycle.
  logic mode_ff; // Applied offset mode.

  // Debounce all switch inputs together before decoding.
  switch_debounce #(
    .WIDTH(16),
    .STABLE_CYC(swcfg_pkg::DEBOUNCE_CYC)
  ) u_deb (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw_in({option_switch_bank, rotary_hi, rotary_lo}),
    .clean_out(clean_sw)
  );

  // Decode address and options from the clean switch image.
  always_comb begin
    opt = clean_sw[15:8];
    sw_addr = 8'(clean_sw[7:4] * swcfg_pkg::DIGIT_WEIGHT) + {4'h0, clean_sw[3:0]};
    def_sel = (sw_addr == swcfg_pkg::SW_DEFAULT_CODE);
    if (def_sel) begin
      nxt_setup = swcfg_pkg::DEF_SETUP;
      nxt_cksum = swcfg_pkg::DEF_CKSUM;
      nxt_baud = swcfg_pkg::BAUD_115200;
      nxt_mode = swcfg_pkg::DEF_MODE;
    end else begin
      nxt_setup = opt[swcfg_pkg::OPT_SETUP_BIT];
      nxt_cksum = opt[swcfg_pkg::OPT_CKSUM_BIT];
      nxt_baud = opt[swcfg_pkg::OPT_BAUD_LSB +: 3];
      nxt_mode = opt[swcfg_pkg::OPT_MODE_BIT];
    end
    if (nxt_mode) begin
      nxt_dev = sw_addr + swcfg_pkg::OFFSET_ADD;
      nxt_base = sw_addr;
    end else begin
      nxt_dev = sw_addr;
      nxt_base = sw_addr + swcfg_pkg::SLOT_STEP;
    end
    // The last slot address must stay within the accepted range.
    nxt_valid = ({1'b0, sw_addr} + 9'(swcfg_pkg::NUM_SLOTS) - {8'h00, nxt_mode})
                <= {1'b0, swcfg_pkg::ADDR_MAX};
    changed = (clean_sw != prev_sw_ff);
  end

  // Apply sequencer: a switch change re-applies all parameters on its own.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seq_ff <= swcfg_pkg::SEQ_PUSH;
      prev_sw_ff <= '0;
      param_apply <= 1'b0;
    end else begin
      param_apply <= 1'b0;
      case (seq_ff)
        swcfg_pkg::SEQ_IDLE: begin
          if (changed) begin
            seq_ff <= swcfg_pkg::SEQ_PUSH;
          end
        end
        swcfg_pkg::SEQ_PUSH: begin
          prev_sw_ff <= clean_sw;
          param_apply <= 1'b1;
          seq_ff <= swcfg_pkg::SEQ_WAIT;
        end
        swcfg_pkg::SEQ_WAIT: begin
          seq_ff <= swcfg_pkg::SEQ_IDLE;
        end
        default: begin
          seq_ff <= swcfg_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Latch the decoded parameters when they are applied.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dev_addr <= '0;
      addr_valid <= 1'b0;
      auto_setup <= swcfg_pkg::DEF_SETUP;
      cksum_en <= swcfg_pkg::DEF_CKSUM;
      baud_code <= swcfg_pkg::BAUD_115200;
      slot_baud <= swcfg_pkg::BAUD_115200;
      slot_cksum <= swcfg_pkg::DEF_CKSUM;
      mode_ff <= swcfg_pkg::DEF_MODE;
      slot_addr <= '0;
    end else if (seq_ff == swcfg_pkg::SEQ_PUSH) begin
      dev_addr <= nxt_dev;
      addr_valid <= nxt_valid;
      auto_setup <= nxt_setup;
      cksum_en <= nxt_cksum;
      baud_code <= nxt_baud;
      slot_baud <= nxt_baud;
      slot_cksum <= nxt_cksum;
      mode_ff <= nxt_mode;
      slot_addr <= nxt_slot;
    end
  end

  // Slot addresses count upward from the slot 0 address.
  genvar gi;
  generate
    for (gi = 0; gi < swcfg_pkg::NUM_SLOTS; gi++) begin : g_slot
      // Each slot adds its own index; the result is latched with the other parameters.
      assign nxt_slot[gi*8 +: 8] = nxt_base + 8'(gi);
      assign busy_v[gi] = (slot_state[gi*2 +: 2] == swcfg_pkg::ST_BUSY);
      assign fail_v[gi] = (slot_state[gi*2 +: 2] == swcfg_pkg::ST_FAIL);
    end
  endgenerate

  // Blink dividers: fast toggles every 100 ms, slow every second for a 2 s period.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_ff <= '0;
      slow_cnt_ff <= '0;
      fast_ff <= 1'b0;
      slow_ff <= 1'b0;
    end else begin
      if (fast_cnt_ff == 23'(swcfg_pkg::FAST_CYC - 1)) begin
        fast_cnt_ff <= '0;
        fast_ff <= ~fast_ff;
      end else begin
        fast_cnt_ff <= fast_cnt_ff + 23'h000001;
      end
      if (slow_cnt_ff == 25'(swcfg_pkg::SLOW_CYC - 1)) begin
        slow_cnt_ff <= '0;
        slow_ff <= ~slow_ff;
      end else begin
        slow_cnt_ff <= slow_cnt_ff + 25'h0000001;
      end
    end
  end

  // Indicator drivers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slot_led <= '0;
      ready_led <= 1'b0;
      setup_led <= 1'b0;
    end else begin
      slot_led <= (busy_v & {8{fast_ff}}) | (fail_v & {8{slow_ff}});
      if (|busy_v) begin
        ready_led <= fast_ff;
      end else if (|fail_v) begin
        ready_led <= slow_ff;
      end else begin
        ready_led <= 1'b1;
      end
      setup_led <= auto_setup;
    end
  end

  // Interrupt events: parameter change, new failure, setup finished.
  always_comb begin
    irq_set = '0;
    irq_set[swcfg_pkg::IRQ_CHANGE] = param_apply;
    irq_set[swcfg_pkg::IRQ_FAIL] = |(fail_v & ~fail_prev_ff);
    irq_set[swcfg_pkg::IRQ_DONE] = busy_prev_ff & ~(|busy_v);
  end

  // Sticky status; a set in the clear cycle wins over the clear.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
      irq_en_ff <= '0;
      fail_prev_ff <= '0;
      busy_prev_ff <= 1'b0;
      irq <= 1'b0;
    end else begin
      fail_prev_ff <= fail_v;
      busy_prev_ff <= |busy_v;
      if (reg_wr && reg_addr == swcfg_pkg::REG_IRQ_CLEAR) begin
        irq_stat_ff <= (irq_stat_ff & ~reg_wdata[2:0]) | irq_set;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_set;
      end
      if (reg_wr && reg_addr == swcfg_pkg::REG_IRQ_ENABLE) begin
        irq_en_ff <= reg_wdata[2:0];
      end
      irq <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // Read port: data stand one cycle after the read strobe.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        swcfg_pkg::REG_CONFIG: reg_rdata <= {addr_valid, mode_ff, baud_code, cksum_en,
                                             auto_setup, 1'b0};
        swcfg_pkg::REG_CPU_ADDR: reg_rdata <= dev_addr;
        swcfg_pkg::REG_SLOT0_ADDR: reg_rdata <= slot_addr[7:0];
        swcfg_pkg::REG_IRQ_STATUS: reg_rdata <= {5'h00, irq_stat_ff};
        swcfg_pkg::REG_IRQ_ENABLE: reg_rdata <= {5'h00, irq_en_ff};
        swcfg_pkg::REG_SLOT_STATE: reg_rdata <= fail_v | busy_v;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Checks on the decoded values, the apply sequencer and the lamps.
  // The sampled rst_n term keeps attempts started on the last reset edge quiet,
  // since the outputs still hold their reset values one edge later.
  chk_dev_addr_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    (seq_ff == swcfg_pkg::SEQ_PUSH && nxt_mode) |=> dev_addr == $past(sw_addr) + 8'h80)
    else $error("device address wrong in offset mode");
  chk_slot_base_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_n && seq_ff == swcfg_pkg::SEQ_PUSH && !nxt_mode) |=>
      slot_addr[7:0] == dev_addr + 8'h01)
    else $error("slot 0 address wrong in normal mode");
  chk_slot_step: assert property (@(posedge mclk) disable iff (!rst_n)
    (seq_ff != swcfg_pkg::SEQ_PUSH) |-> slot_addr[15:8] == slot_addr[7:0] + 8'h01)
    else $error("slot 1 address not one above slot 0");
  chk_default_opts: assert property (@(posedge mclk) disable iff (!rst_n)
    (seq_ff == swcfg_pkg::SEQ_PUSH && def_sel) |=> auto_setup && !cksum_en && baud_code == 3'h7)
    else $error("defaults not applied for code 00");
  chk_slot_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    slot_baud == baud_code && slot_cksum == cksum_en)
    else $error("slot settings differ from device");
  chk_change_apply: assert property (@(posedge mclk) disable iff (!rst_n)
    (seq_ff == swcfg_pkg::SEQ_IDLE && changed) |-> ##2 param_apply)
    else $error("switch change not applied");
  chk_setup_led: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |=> setup_led == $past(auto_setup))
    else $error("setup lamp does not follow enable");
  chk_ready_pass: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_n && busy_v == 8'h00 && fail_v == 8'h00) |=> ready_led)
    else $error("ready lamp not lit when all pass");
  chk_ready_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_n && busy_v != 8'h00) |=> ready_led == $past(fast_ff))
    else $error("ready lamp not at fast rate during setup");
  chk_slot_pass_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (!busy_v[0] && !fail_v[0]) |=> !slot_led[0])
    else $error("slot lamp lit after pass");
  chk_slot_fail_flash: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_n && fail_v[0] && !busy_v[0]) |=> slot_led[0] == $past(slow_ff))
    else $error("slot lamp not at slow rate on failure");

endmodule // switch_address_config

/* File: verification/slot_manager_model.sv */
// Behavioural slot manager that reports per-slot setup results to the block.
// Assumes one clock; every parameter push restarts setup of all eight slots.
`timescale 1ns/1ns
module slot_manager_model #(
  parameter int unsigned BUSY_CYC = 100
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Parameter push from the block.
  input wire logic param_apply,
  // Slots whose modules fail their setup once the busy time is over.
  input wire logic [7:0] fail_mask,
  // Setup results, two bits per slot.
  output logic [15:0] slot_state
);
  // Cycles left in the current setup pass.
  int busy_cnt;

  // Each push makes every slot busy for a while, then each slot passes, or fails where fail_mask is set.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 0;
    end else if (param_apply) begin
      busy_cnt <= BUSY_CYC;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end

  // Busy code on every slot while counting, then pass, or fail where the mask says so.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      slot_state[i*2 +: 2] = (busy_cnt > 0) ? 2'h1 : {1'b1, fail_mask[i]};
    end
  end
endmodule // slot_manager_model

/* File: verification/testbench.sv */
// Self-checking bench for the switch address and configuration block.
// Assumes the design files are compiled first and a slot manager model sits beside the block.
`timescale 1ns/1ns
module testbench;
  // Clock, reset and block inputs.
  logic mclk;
  logic rst_n;
  logic [3:0] rotary_hi;
  logic [3:0] rotary_lo;
  logic [7:0] option_switch_bank;
  logic [15:0] slot_state;
  logic [7:0] fail_mask; // Slots whose modules the partner makes fail.
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  // Block outputs.
  logic [7:0] reg_rdata;
  logic [7:0] dev_addr;
  logic [63:0] slot_addr;
  logic addr_valid, auto_setup, cksum_en, slot_cksum, param_apply;
  logic [2:0] baud_code;
  logic [2:0] slot_baud;
  logic [7:0] slot_led;
  logic ready_led, setup_led, irq;
  // Counters of the report.
  int n_mismatch;
  int check_count;
  logic [7:0] rd_val;

  switch_address_config uut (.mclk(mclk), .rst_n(rst_n), .rotary_hi(rotary_hi),
    .rotary_lo(rotary_lo), .option_switch_bank(option_switch_bank), .slot_state(slot_state),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dev_addr(dev_addr), .slot_addr(slot_addr),
    .addr_valid(addr_valid), .auto_setup(auto_setup), .cksum_en(cksum_en),
    .baud_code(baud_code), .slot_baud(slot_baud), .slot_cksum(slot_cksum),
    .param_apply(param_apply), .slot_led(slot_led), .ready_led(ready_led),
    .setup_led(setup_led), .irq(irq));

  slot_manager_model partner (.mclk(mclk), .rst_n(rst_n), .param_apply(param_apply),
    .fail_mask(fail_mask), .slot_state(slot_state));

  // Free-running 20 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares one value of any width up to 64 bits.
  task automatic check_val(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle register write.
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read; the data stand in the following cycle only.
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Waits for the next parameter push and checks that the debounce time was kept.
  task automatic wait_apply();
    int n;
    n = 0;
    while (param_apply !== 1'b1) begin
      @(posedge mclk);
      #1 n++;
      if (n > swcfg_pkg::DEBOUNCE_CYC + 100) begin
        n_mismatch++;
        $display("Error param_apply expected 1 seen %b", param_apply);
        tally_and_finish();
      end
    end
    check_val("debounce_wait", 1, n >= swcfg_pkg::DEBOUNCE_CYC);
  endtask

  // Switches are changed only here, between checks, never during register traffic.
  task automatic set_switches(input logic [3:0] hi, input logic [3:0] lo, input logic [7:0] op);
    @(posedge mclk);
    rotary_hi <= hi;
    rotary_lo <= lo;
    option_switch_bank <= op;
  endtask

  // Code 00 with options set: the options are ignored and defaults apply.
  task automatic scen_zero_code();
    wait_apply();
    check_val("auto_setup", 1, auto_setup);
    check_val("cksum_en", 0, cksum_en);
    check_val("baud_code", swcfg_pkg::BAUD_115200, baud_code);
    check_val("dev_addr", 8'h00, dev_addr);
    check_val("slot0", 8'h01, slot_addr[7:0]);
    check_val("setup_led", 1, setup_led);
    reg_read(4'hf, rd_val);
    check_val("unmapped", 8'h00, rd_val);
  endtask

  // Normal mode at address 16 with checksum and a slow baud code.
  task automatic scen_normal_mode();
    reg_write(swcfg_pkg::REG_IRQ_ENABLE, 8'h01);
    reg_write(swcfg_pkg::REG_IRQ_CLEAR, 8'h07);
    repeat (2) @(posedge mclk);
    #1 check_val("irq_cleared", 0, irq);
    set_switches(4'h1, 4'h0, 8'h0a);
    wait_apply();
    check_val("dev_addr", 8'h10, dev_addr);
    check_val("slot0", 8'h11, slot_addr[7:0]);
    check_val("slot7", 8'h18, slot_addr[63:56]);
    check_val("addr_valid", 1, addr_valid);
    check_val("cksum_en", 1, cksum_en);
    check_val("baud_code", 3'h2, baud_code);
    check_val("slot_cksum", 1, slot_cksum);
    check_val("slot_baud", 3'h2, slot_baud);
    check_val("auto_setup", 0, auto_setup);
    @(posedge mclk);
    #1 check_val("setup_led", 0, setup_led);
    // The status bit sets one edge after the push and the line follows one edge later.
    @(posedge mclk);
    #1 check_val("irq_raised", 1, irq);
    reg_read(swcfg_pkg::REG_IRQ_STATUS, rd_val);
    check_val("irq_status", 1, rd_val[swcfg_pkg::IRQ_CHANGE]);
    reg_write(swcfg_pkg::REG_IRQ_CLEAR, 8'h01);
    repeat (150) @(posedge mclk);
    #1 check_val("irq_after_clear", 0, irq);
    check_val("ready_led", 1, ready_led);
    check_val("slot_led", 8'h00, slot_led);
  endtask

  // Offset mode at the top address, interrupt masked.
  task automatic scen_offset_mode();
    reg_write(swcfg_pkg::REG_IRQ_ENABLE, 8'h00);
    set_switches(4'h7, 4'hf, 8'h21);
    wait_apply();
    check_val("dev_addr", 8'hff, dev_addr);
    check_val("slot0", 8'h7f, slot_addr[7:0]);
    check_val("slot1", 8'h80, slot_addr[15:8]);
    check_val("addr_valid", 0, addr_valid);
    check_val("baud_code", 3'h0, baud_code);
    check_val("slot_baud", 3'h0, slot_baud);
    repeat (3) @(posedge mclk);
    #1 check_val("irq_masked", 0, irq);
    check_val("setup_led", 1, setup_led);
    reg_read(swcfg_pkg::REG_CPU_ADDR, rd_val);
    check_val("reg_cpu_addr", 8'hff, rd_val);
  endtask

  // Slot 0 fails its setup: new-failure interrupt, ready lamp and slot state show it.
  task automatic scen_slot_fail();
    repeat (120) @(posedge mclk);
    reg_write(swcfg_pkg::REG_IRQ_ENABLE, 8'h02);
    @(posedge mclk);
    #1 check_val("irq_before_fail", 0, irq);
    @(posedge mclk);
    fail_mask <= 8'h01;
    repeat (3) @(posedge mclk);
    #1 check_val("irq_fail", 1, irq);
    check_val("ready_led_fail", 0, ready_led);
    reg_read(swcfg_pkg::REG_SLOT_STATE, rd_val);
    check_val("slot_active", 8'h01, rd_val);
    reg_read(swcfg_pkg::REG_IRQ_STATUS, rd_val);
    check_val("irq_status_all", 8'h07, rd_val);
  endtask

  // Main sequence.
  initial begin
    n_mismatch = 0;
    check_count = 0;
    rst_n = 1'b0;
    rotary_hi = 4'h0;
    rotary_lo = 4'h0;
    option_switch_bank = 8'h26;
    fail_mask = 8'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    scen_zero_code();
    scen_normal_mode();
    scen_offset_mode();
    scen_slot_fail();
    tally_and_finish();
  end
endmodule // testbench
